// file: core/gls_driver.sv
// Gate line scan driver: bidirectional scan chain, group blanking, force-all, cascade carry, APB status
`timescale 1ns/100ps
`include "gls_cfg.svh"

module gls_driver (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`GLS_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      shift_clock,
  input  wire logic                      scan_direction_select,
  input  wire logic                      count_strap_a,
  input  wire logic                      count_strap_b,
  input  wire logic                      blank_group_1,
  input  wire logic                      blank_group_2,
  input  wire logic                      blank_group_3,
  input  wire logic                      force_all_select_n,
  input  wire logic                      first_end_pulse_pin_in,
  output logic                           first_end_pulse_pin_out,
  output logic                           first_end_pulse_pin_oe,
  input  wire logic                      last_end_pulse_pin_in,
  output logic                           last_end_pulse_pin_out,
  output logic                           last_end_pulse_pin_oe,
  output logic      [`GLS_NUM_OUT-1:0]   gate_outputs
);

  // Chain position of a physical output in a mode, or -1 when removed
  function automatic int lidx(input int p, input logic [1:0] m);
    int lo;
    int hi;
    lo = `GLS_NUM_OUT;
    hi = `GLS_NUM_OUT;
    case (m)
      2'b00: begin
        lo = `GLS_SKIP200_LO;
        hi = `GLS_SKIP200_HI;
      end
      2'b01: begin
        lo = `GLS_SKIP240_LO;
        hi = `GLS_SKIP240_HI;
      end
      2'b10: begin
        lo = `GLS_SKIP256_LO;
        hi = `GLS_SKIP256_HI;
      end
      default: begin
        lo = `GLS_NUM_OUT;
        hi = `GLS_NUM_OUT;
      end
    endcase
    if (p < lo)
      return p;
    else if (p <= hi)
      return -1;
    else
      return p - (hi - lo + 1);
  endfunction

  // Active stage count for a strap setting
  function automatic logic [`GLS_IDX_W-1:0] mode_count(input gls_pkg::gls_mode_t m);
    logic [`GLS_IDX_W-1:0] n;
    case (m)
      gls_pkg::GLS_M200: n = `GLS_IDX_W'(`GLS_CNT_200);
      gls_pkg::GLS_M240: n = `GLS_IDX_W'(`GLS_CNT_240);
      gls_pkg::GLS_M256: n = `GLS_IDX_W'(`GLS_CNT_256);
      default:           n = `GLS_IDX_W'(`GLS_CNT_263);
    endcase
    return n;
  endfunction

  // Chain position of one physical output under the current straps
  function automatic int pick_idx(input gls_pkg::gls_mode_t m, input int i200, input int i240,
                                  input int i256, input int i263);
    int r;
    case (m)
      gls_pkg::GLS_M200: r = i200;
      gls_pkg::GLS_M240: r = i240;
      gls_pkg::GLS_M256: r = i256;
      default:           r = i263;
    endcase
    return r;
  endfunction

  // Register hit tests, shared by the error, write and read paths
  function automatic logic hit_ctrl(input logic [`GLS_ADDR_W-1:0] a);
    return a == `GLS_OFS_CTRL;
  endfunction

  function automatic logic hit_status(input logic [`GLS_ADDR_W-1:0] a);
    return a == `GLS_OFS_STATUS;
  endfunction

  // Status word: straps, direction, carry and shift edges since the last start
  function automatic logic [31:0] status_word(input gls_pkg::gls_pins_t s, input logic c,
                                              input logic [`GLS_IDX_W-1:0] n);
    logic [31:0] w;
    w = '0;
    w[`GLS_ST_MODE_LO +: 2]         = s.mode;
    w[`GLS_ST_DIR]                  = s.dir;
    w[`GLS_ST_CARRY]                = c;
    w[`GLS_ST_CNT_LO +: `GLS_IDX_W] = n;
    return w;
  endfunction

  gls_pkg::gls_pins_t           pins_raw;
  gls_pkg::gls_pins_t           sync1_reg;
  gls_pkg::gls_pins_t           sync2_reg;
  logic                         sclk_prev_reg;
  logic                         rise;
  logic                         fall;
  logic [`GLS_IDX_W-1:0]        act_cnt;
  logic                         start_bit;
  logic                         far_bit;
  logic [`GLS_NUM_OUT-1:0]      chain_reg;
  logic [`GLS_NUM_OUT-1:0]      chain_next;
  logic                         carry_reg;
  logic                         ctrl_blank_reg;
  logic [`GLS_IDX_W-1:0]        edge_cnt_reg;
  logic                         setup;
  logic                         addr_ok;

  assign pins_raw = '{dir:     scan_direction_select,
                      mode:    gls_pkg::gls_mode_t'({count_strap_a, count_strap_b}),
                      blank:   {blank_group_3, blank_group_2, blank_group_1},
                      force_n: force_all_select_n,
                      first_in: first_end_pulse_pin_in,
                      last_in: last_end_pulse_pin_in,
                      sclk:    shift_clock};

  // Every pin is asynchronous to pclk; the open force input settles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= `GLS_PINS_RST;
      sync2_reg <= `GLS_PINS_RST;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sclk_prev_reg <= 1'b0;
    else
      sclk_prev_reg <= sync2_reg.sclk;
  end

  assign rise = sync2_reg.sclk & ~sclk_prev_reg;
  assign fall = ~sync2_reg.sclk & sclk_prev_reg;

  assign act_cnt = mode_count(sync2_reg.mode);

  // Start enters on the pin facing the scan origin, carry leaves the other end
  assign start_bit = sync2_reg.dir ? sync2_reg.first_in : sync2_reg.last_in;
  assign far_bit   = sync2_reg.dir ? chain_reg[act_cnt - `GLS_IDX_W'(1)] : chain_reg[0];

  always_comb begin
    chain_next = '0;
    for (int k = 0; k < `GLS_NUM_OUT; k++) begin
      if (k < int'(act_cnt)) begin
        if (sync2_reg.dir)
          chain_next[k] = (k == 0) ? start_bit : chain_reg[k-1];
        else if (k == int'(act_cnt) - 1)
          chain_next[k] = start_bit;
        else
          chain_next[k] = chain_reg[k+1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      chain_reg <= '0;
    else if (rise)
      chain_reg <= chain_next;
  end

  // Carry is the far stage re-timed to the falling edge for the next device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      carry_reg <= 1'b0;
    else if (fall)
      carry_reg <= far_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_end_pulse_pin_oe <= 1'b0;
      last_end_pulse_pin_oe  <= 1'b0;
    end else begin
      first_end_pulse_pin_oe <= ~sync2_reg.dir;
      last_end_pulse_pin_oe  <= sync2_reg.dir;
    end
  end

  // One flop per pin keeps the input-side pin quiet while the far pin carries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_end_pulse_pin_out <= 1'b0;
      last_end_pulse_pin_out  <= 1'b0;
    end else if (fall) begin
      first_end_pulse_pin_out <= ~sync2_reg.dir & far_bit;
      last_end_pulse_pin_out  <= sync2_reg.dir & far_bit;
    end
  end

  // Overrides ride the same two-flop sync, so they lag the pin by about three pclk
  generate
    for (genvar p = 0; p < `GLS_NUM_OUT; p++) begin : g_out
      localparam int L200 = lidx(p, 2'b00);
      localparam int L240 = lidx(p, 2'b01);
      localparam int L256 = lidx(p, 2'b10);
      localparam int L263 = lidx(p, 2'b11);
      int   li;
      logic level;

      always_comb begin
        li = pick_idx(sync2_reg.mode, L200, L240, L256, L263);
        // Force lights removed outputs too: it acts on every pin, chained or not
        if (!sync2_reg.force_n)
          level = 1'b1;
        else if (li < 0 || ctrl_blank_reg)
          level = 1'b0;
        else if (sync2_reg.blank[li % `GLS_NUM_GROUPS])
          level = 1'b0;
        else
          level = chain_reg[li];
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          gate_outputs[p] <= 1'b0;
        else
          gate_outputs[p] <= level;
      end
    end
  endgenerate

  // Shift edges since the last start pulse, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      edge_cnt_reg <= '0;
    else if (rise && start_bit)
      edge_cnt_reg <= '0;
    else if (rise && edge_cnt_reg != `GLS_CNT_MAX)
      edge_cnt_reg <= edge_cnt_reg + `GLS_IDX_W'(1);
  end

  // APB: one wait-free access phase, answer registered in the setup cycle
  assign setup   = psel & ~penable;
  assign addr_ok = hit_ctrl(paddr) || hit_status(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_blank_reg <= `GLS_CTRL_RST;
    else if (psel && penable && pready && pwrite && hit_ctrl(paddr))
      ctrl_blank_reg <= pwdata[`GLS_CTRL_BLANK];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok;
    end
  end

  // Read data is latched in the setup cycle, so it stands through the access cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= '0;
      if (setup && !pwrite && hit_ctrl(paddr))
        prdata[`GLS_CTRL_BLANK] <= ctrl_blank_reg;
      else if (setup && !pwrite && hit_status(paddr))
        prdata <= status_word(sync2_reg, carry_reg, edge_cnt_reg);
    end
  end

endmodule

// file: core/gls_cfg.svh
// Constants for the gate line scan driver: counts, skip windows, offsets, reset values
`ifndef GLS_CFG_SVH
`define GLS_CFG_SVH

`define GLS_NUM_OUT       263
`define GLS_IDX_W         9
`define GLS_CNT_200       200
`define GLS_CNT_240       240
`define GLS_CNT_256       256
`define GLS_CNT_263       263
// Removed windows, zero-based physical output index, inclusive
`define GLS_SKIP200_LO    100
`define GLS_SKIP200_HI    162
`define GLS_SKIP240_LO    120
`define GLS_SKIP240_HI    142
`define GLS_SKIP256_LO    128
`define GLS_SKIP256_HI    134
`define GLS_NUM_GROUPS    3
// APB map
`define GLS_OFS_CTRL      12'h000
`define GLS_OFS_STATUS    12'h004
`define GLS_ADDR_W        12
`define GLS_CTRL_BLANK    0
`define GLS_ST_MODE_LO    0
`define GLS_ST_DIR        2
`define GLS_ST_CARRY      3
`define GLS_ST_CNT_LO     8
`define GLS_CTRL_RST      1'h0
`define GLS_CNT_MAX       9'h1FF
// Pin sync reset values; force input idles high like its pull-up
`define GLS_PINS_RST      {1'b1, 2'b11, 3'b000, 1'b1, 1'b0, 1'b0, 1'b0}

`endif

// file: core/gls_pkg.sv
// Types for the gate line scan driver
package gls_pkg;

  typedef enum logic [1:0] {
    GLS_M200 = 2'b00,
    GLS_M240 = 2'b01,
    GLS_M256 = 2'b10,
    GLS_M263 = 2'b11
  } gls_mode_t;

  typedef struct packed {
    logic      dir;
    gls_mode_t mode;
    logic [2:0] blank;
    logic      force_n;
    logic      first_in;
    logic      last_in;
    logic      sclk;
  } gls_pins_t;

endpackage

// file: testbench/gls_driver_properties.sv
// Port-level assertions for the gate line scan driver
`timescale 1ns/100ps
`include "gls_cfg.svh"
module gls_driver_chk (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    shift_clock,
  input wire logic                    scan_direction_select,
  input wire logic                    count_strap_a,
  input wire logic                    count_strap_b,
  input wire logic                    blank_group_1,
  input wire logic                    force_all_select_n,
  input wire logic                    first_end_pulse_pin_oe,
  input wire logic                    last_end_pulse_pin_oe,
  input wire logic                    last_end_pulse_pin_out,
  input wire logic [`GLS_NUM_OUT-1:0] gate_outputs
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ANSWER_NEXT: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_FORCE_ALL: assert property ((!force_all_select_n)[*8] |-> &gate_outputs)
    else $error("force did not select all");
  AST_BLANK_FIRST: assert property ((blank_group_1 && force_all_select_n)[*8] |-> !gate_outputs[0])
    else $error("output 1 not blanked");
  AST_DIR_HIGH_OE: assert property (scan_direction_select[*6] |-> last_end_pulse_pin_oe && !first_end_pulse_pin_oe)
    else $error("wrong carry pin for high direction");
  AST_DIR_LOW_OE: assert property ((!scan_direction_select)[*6] |-> first_end_pulse_pin_oe && !last_end_pulse_pin_oe)
    else $error("wrong carry pin for low direction");
  AST_SKIP_200: assert property ((!count_strap_a && !count_strap_b && force_all_select_n)[*8] |->
    gate_outputs[162:100] == '0) else $error("removed output active");
  AST_CARRY_FALL: assert property ($changed(last_end_pulse_pin_out) |-> !shift_clock)
    else $error("carry moved outside low phase");
endmodule

bind gls_driver gls_driver_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .shift_clock,
  .scan_direction_select, .count_strap_a, .count_strap_b, .blank_group_1, .force_all_select_n,
  .first_end_pulse_pin_oe, .last_end_pulse_pin_oe, .last_end_pulse_pin_out, .gate_outputs);

// file: testbench/gls_tcon.sv
// Timing controller model: drives shift clock and start pulse
`timescale 1ns/100ps
module gls_tcon #(
  parameter int HALF = 10
) (
  input  wire logic pclk,
  output logic      shift_clock,
  output logic      start
);
  initial begin
    shift_clock = 1'b0;
    start = 1'b0;
  end
  // One period is 2*HALF+1 pclk, so the clock stays below 500 kHz
  task automatic step(input logic st);
    @(posedge pclk);
    start <= st;
    repeat (HALF) @(posedge pclk);
    shift_clock <= 1'b1;
    repeat (HALF) @(posedge pclk);
    shift_clock <= 1'b0;
    start <= 1'b0;
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking testbench for the gate line scan driver
`timescale 1ns/100ps
`include "gls_cfg.svh"
module tb;
  typedef struct packed {
    logic       a;
    logic       b;
    logic       d;
    logic [2:0] m;
    logic [8:0] n;
    logic [8:0] lo;
    logic [8:0] hi;
  } gls_row_t;
  localparam logic [`GLS_NUM_OUT-1:0] ONE = {{`GLS_NUM_OUT-1{1'b0}}, 1'b1};
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [`GLS_ADDR_W-1:0]  paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic                    dir, sa, sb, bg1, bg2, bg3, fn, f_out, f_oe, l_out, l_oe, shift_clock, start;
  logic [`GLS_NUM_OUT-1:0] gate_outputs;
  wire                     f_in = f_oe ? f_out : (dir ? start : ~start);
  wire                     l_in = l_oe ? l_out : (dir ? ~start : start);
  int                      errors, n_compared, pos;
  gls_row_t                rows [4];

  gls_tcon tcon (.pclk, .shift_clock, .start);
  gls_driver DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .shift_clock, .scan_direction_select(dir), .count_strap_a(sa), .count_strap_b(sb), .blank_group_1(bg1),
    .blank_group_2(bg2), .blank_group_3(bg3), .force_all_select_n(fn), .first_end_pulse_pin_in(f_in),
    .first_end_pulse_pin_out(f_out), .first_end_pulse_pin_oe(f_oe), .last_end_pulse_pin_in(l_in),
    .last_end_pulse_pin_out(l_out), .last_end_pulse_pin_oe(l_oe), .gate_outputs);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task chk(input logic [`GLS_NUM_OUT+2:0] got, input logic [`GLS_NUM_OUT+2:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [`GLS_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  function int nxt(int p, gls_row_t r);
    p = r.d ? p + 1 : p - 1;
    if (p >= r.lo && p <= r.hi) p = r.d ? r.hi + 1 : r.lo - 1;
    return p;
  endfunction

  task conclude;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Generous bound: the scans take about 20500 pclk
  initial begin
    #8000000;
    errors++;
    conclude;
  end

  initial begin
    rows[0] = {3'h7, 3'h7, 9'h107, 9'h1FF, 9'h1FF};
    rows[1] = {3'h4, 3'h2, 9'h100, 9'h080, 9'h086};
    rows[2] = {3'h3, 3'h5, 9'h0F0, 9'h078, 9'h08E};
    rows[3] = {3'h0, 3'h0, 9'h0C8, 9'h064, 9'h0A2};
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dir, sa, sb, bg1, bg2, bg3, fn} = 7'h71;
    errors = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    chk({gate_outputs, f_oe, l_oe, pready}, '0);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `GLS_OFS_CTRL, 32'h0);
    chk(rd, `GLS_CTRL_RST);
    apb(1'b0, 12'h008, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    foreach (rows[i]) begin
      {sa, sb, dir} <= {rows[i].a, rows[i].b, rows[i].d};
      repeat (8) @(posedge pclk);
      apb(1'b0, `GLS_OFS_STATUS, 32'h0);
      chk(rd[2:0], rows[i].m);
      pos = rows[i].d ? 0 : `GLS_NUM_OUT - 1;
      tcon.step(1'b1);
      for (int k = 0; k < rows[i].n; k++) begin
        if (k > 0) begin
          tcon.step(1'b0);
          pos = nxt(pos, rows[i]);
        end
        chk(gate_outputs, ONE << pos);
      end
      repeat (5) @(posedge pclk);
      chk(rows[i].d ? {l_out, l_oe} : {f_out, f_oe}, 2'h3);
      apb(1'b0, `GLS_OFS_STATUS, 32'h0);
      chk({rd[16:8], rd[3]}, {rows[i].n - 9'h001, 1'b1});
      tcon.step(1'b0);
      chk(gate_outputs, '0);
      repeat (5) @(posedge pclk);
      chk({f_out, l_out}, 2'h0);
    end
    {sa, sb, dir} <= 3'h7;
    repeat (8) @(posedge pclk);
    tcon.step(1'b1);
    tcon.step(1'b0);
    bg1 <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(gate_outputs, ONE << 1);
    bg2 <= 1'b1;
    bg3 <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(gate_outputs, '0);
    fn <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(gate_outputs, {`GLS_NUM_OUT{1'b1}});
    {fn, bg1, bg2, bg3} <= 4'h8;
    repeat (8) @(posedge pclk);
    chk(gate_outputs, ONE << 1);
    apb(1'b1, `GLS_OFS_CTRL, 32'h1);
    repeat (8) @(posedge pclk);
    chk(gate_outputs, '0);
    apb(1'b0, `GLS_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({gate_outputs, f_oe, l_oe}, '0);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({gate_outputs, f_oe, l_oe}, {{`GLS_NUM_OUT{1'b0}}, 2'h1});
    apb(1'b0, `GLS_OFS_CTRL, 32'h0);
    chk(rd, `GLS_CTRL_RST);
    conclude;
  end
endmodule
